/* File: rtl/sfce_engine.sv */
// serial flash command engine: opcode decode, reads, ids, page program
//
// Function
// - single read: opcode, 24-bit address, data
// - host bits sampled on serial clock rise
// - output bits change on serial clock fall
// - everything travels most significant bit first
// - read address increments after each byte
// - read address wraps to zero at top
// - data streams until select rises
// - reads and ids ignored while busy
// - fast read has eight dummy clocks
// - select rise stops data drive
// - dual read: address, data two bits/clock
// - quad read: address, data four bits/clock
// - dual four, quad six dummy clocks
// - device id byte shifted out once
// - silicon id after three dummy bytes, repeats
// - write enable opcode sets latch
// - latch cleared by disable, reset, completion
// - program data wraps inside its page
// - last 256 bytes win, others untouched
// - select rise starts timed cycle, busy flag
// - quad program takes data four bits/clock
`timescale 1ns/1ps

module sfce_engine #(
  parameter int         MEM_ADDR_W = 16,
  parameter logic [7:0] DEVICE_ID  = 8'hC3, // arbitrary value
  parameter logic [7:0] SILICON_ID = 8'h3C  // arbitrary value
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       select_active_low_i,
  input  wire logic       serial_clock_i,
  input  wire logic [3:0] io_line_i,
  output logic      [3:0] io_line_o,
  output logic      [3:0] io_line_oe_o,
  output logic            write_in_progress_o,
  output logic            write_enable_latch_o
);
  import sfce_pkg::*;

  // ****************************************************************
  // command table
  // ****************************************************************
  function automatic sfce_cmd_t decode(input logic [7:0] op);
    sfce_cmd_t c;
    c = '{K_NONE, LANES_1, LANES_1, ADDR_CLKS_1, DUMMY_NONE};
    case (op)
      OP_READ:  c.kind = K_READ;
      OP_FAST:  c = '{K_READ, LANES_1, LANES_1, ADDR_CLKS_1, DUMMY_FAST};
      OP_DUAL:  c = '{K_READ, LANES_2, LANES_2, ADDR_CLKS_2, DUMMY_DUAL};
      OP_QUAD:  c = '{K_READ, LANES_4, LANES_4, ADDR_CLKS_4, DUMMY_QUAD};
      OP_DEVID: c.kind = K_DEVID;
      OP_SILID: c = '{K_SILID, LANES_1, LANES_1, SILID_CLKS, DUMMY_NONE};
      OP_WREN:  c.kind = K_WREN;
      OP_WRDI:  c.kind = K_WRDI;
      OP_PROG:  c.kind = K_PROG;
      OP_QPROG: c = '{K_PROG, LANES_1, LANES_4, ADDR_CLKS_1, DUMMY_NONE};
      default:  c.kind = K_NONE;
    endcase
    return c;
  endfunction

  function automatic logic [4:0] byte_clks(input logic [2:0] lanes);
    logic [4:0] n;
    n = BYTE_CLKS_1;
    if (lanes == LANES_4) begin
      n = BYTE_CLKS_4;
    end else if (lanes == LANES_2) begin
      n = BYTE_CLKS_2;
    end
    return n;
  endfunction

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  logic       sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic       cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic [3:0] io_s1_reg, io_s2_reg;

  // data and clock share one latency, so sampled bits stay aligned
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg   <= 1'b1;
      cs_s2_reg   <= 1'b1;
      cs_s3_reg   <= 1'b1;
      io_s1_reg   <= 4'h0;
      io_s2_reg   <= 4'h0;
    end else begin
      sclk_s1_reg <= serial_clock_i;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg   <= select_active_low_i;
      cs_s2_reg   <= cs_s1_reg;
      cs_s3_reg   <= cs_s2_reg;
      io_s1_reg   <= io_line_i;
      io_s2_reg   <= io_s1_reg;
    end
  end

  wire cs_high   = cs_s2_reg;
  wire cs_rise   = cs_s2_reg & ~cs_s3_reg;
  wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg & ~cs_high;
  wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg & ~cs_high;

  // ****************************************************************
  // state and storage
  // ****************************************************************
  sfce_state_t           state_reg, state_next;
  sfce_cmd_t             cmd_reg, cmd_next;
  logic [4:0]            cnt_reg, cnt_next;
  logic [2:0]            lanes_reg, lanes_next;
  logic [ADDR_BITS-1:0]  rx_reg;
  logic [MEM_ADDR_W-1:0] addr_reg;
  logic [7:0]            out_sh_reg;
  logic [4:0]            ocnt_reg;
  logic [3:0]            io_out_reg, io_oe_reg;
  logic                  wel_reg, wip_reg, byte_seen_reg;
  logic [BUSY_CNT_W-1:0] busy_cnt_reg;
  logic [PAGE_BYTES-1:0] pvalid_reg;
  logic [7:0]            pbuf [0:PAGE_BYTES-1];
  logic [7:0]            mem  [0:(2**MEM_ADDR_W)-1];

  // ****************************************************************
  // shifting in and decode
  // ****************************************************************
  logic [ADDR_BITS-1:0] rx_shift;
  always_comb begin
    rx_shift = {rx_reg[ADDR_BITS-2:0], io_s2_reg[0]};
    if (lanes_reg == LANES_4) begin
      rx_shift = {rx_reg[ADDR_BITS-5:0], io_s2_reg[3:0]};
    end else if (lanes_reg == LANES_2) begin
      rx_shift = {rx_reg[ADDR_BITS-3:0], io_s2_reg[1:0]};
    end
  end

  wire sfce_cmd_t cmd_dec = decode(rx_shift[7:0]);
  wire last        = (cnt_reg == 5'h00);
  wire opcode_done = sclk_rise & (state_reg == ST_OPCODE) & last;
  wire addr_done   = sclk_rise & (state_reg == ST_ADDR) & last;
  wire prog_byte   = sclk_rise & (state_reg == ST_PROG) & last;
  wire tx_fall     = sclk_fall & (state_reg == ST_DATA);
  wire byte_end    = tx_fall & (ocnt_reg == ONE_CLK);
  wire is_read     = (cmd_reg.kind == K_READ);
  wire prog_start  = cs_rise & (state_reg == ST_PROG) & byte_seen_reg;
  wire busy_done   = wip_reg & (busy_cnt_reg == BUSY_CNT_W'(PROG_CYCLES-1));

  always_comb begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    cnt_next   = cnt_reg;
    lanes_next = lanes_reg;
    if (cs_high) begin
      // select high ends every command
      state_next = ST_OPCODE;
      cnt_next   = OPCODE_CLKS - ONE_CLK;
      lanes_next = LANES_1;
    end else if (sclk_rise) begin
      cnt_next = cnt_reg - ONE_CLK;
      case (state_reg)
        ST_OPCODE: begin
          if (last) begin
            cmd_next   = cmd_dec;
            state_next = ST_IGNORE;
            if (wip_reg) begin
              state_next = ST_IGNORE;
            end else if (cmd_dec.kind == K_READ ||
                         cmd_dec.kind == K_SILID ||
                         (cmd_dec.kind == K_PROG && wel_reg)) begin
              state_next = ST_ADDR;
              cnt_next   = cmd_dec.addr_clks - ONE_CLK;
              lanes_next = cmd_dec.addr_lanes;
            end else if (cmd_dec.kind == K_DEVID) begin
              state_next = ST_DATA;
            end
          end
        end
        ST_ADDR: begin
          if (last) begin
            lanes_next = cmd_reg.data_lanes;
            if (cmd_reg.kind == K_PROG) begin
              state_next = ST_PROG;
              cnt_next   = byte_clks(cmd_reg.data_lanes) - ONE_CLK;
            end else if (cmd_reg.dummy_clks != DUMMY_NONE) begin
              state_next = ST_DUMMY;
              cnt_next   = cmd_reg.dummy_clks - ONE_CLK;
            end else begin
              state_next = ST_DATA;
            end
          end
        end
        ST_DUMMY: begin
          if (last) begin
            state_next = ST_DATA;
          end
        end
        ST_PROG: begin
          if (last) begin
            cnt_next = byte_clks(lanes_reg) - ONE_CLK;
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end else if (byte_end && cmd_reg.kind == K_DEVID) begin
      state_next = ST_IGNORE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= ST_OPCODE;
      cmd_reg   <= '{K_NONE, LANES_1, LANES_1, ADDR_CLKS_1, DUMMY_NONE};
      cnt_reg   <= OPCODE_CLKS - ONE_CLK;
      lanes_reg <= LANES_1;
      rx_reg    <= '0;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      cnt_reg   <= cnt_next;
      lanes_reg <= lanes_next;
      if (sclk_rise) begin
        rx_reg <= rx_shift;
      end
    end
  end

  // ****************************************************************
  // address counter
  // ****************************************************************
  wire [MEM_ADDR_W-1:0] addr_in  = rx_shift[MEM_ADDR_W-1:0];
  wire [MEM_ADDR_W-1:0] addr_inc = addr_reg + MEM_ADDR_W'(1);
  wire [PAGE_BITS-1:0]  page_off = addr_reg[PAGE_BITS-1:0];
  wire [PAGE_BITS-1:0]  off_inc  = page_off + PAGE_BITS'(1);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      addr_reg <= '0;
    end else if (addr_done) begin
      addr_reg <= addr_in;
    end else if (byte_end && is_read) begin
      addr_reg <= addr_inc;
    end else if (prog_byte) begin
      addr_reg <= {addr_reg[MEM_ADDR_W-1:PAGE_BITS], off_inc};
    end
  end

  // ****************************************************************
  // shifting out
  // ****************************************************************
  wire [MEM_ADDR_W-1:0] rd_addr = (state_reg == ST_ADDR) ? addr_in
                                                         : addr_reg;
  wire [7:0] id_byte   = (cmd_reg.kind == K_DEVID) ? DEVICE_ID
                                                   : SILICON_ID;
  wire [7:0] first_src = (cmd_next.kind == K_READ) ? mem[rd_addr]
                       : (cmd_next.kind == K_DEVID) ? DEVICE_ID
                       : SILICON_ID;
  wire [7:0] next_src  = is_read ? mem[addr_inc] : id_byte;
  wire enter_data = sclk_rise & (state_reg != ST_DATA) &
                    (state_next == ST_DATA);

  logic [3:0] drive_bits, drive_oe;
  logic [7:0] sh_left;
  always_comb begin
    drive_bits = {2'b00, out_sh_reg[7], 1'b0};
    drive_oe   = 4'h2;
    sh_left    = {out_sh_reg[6:0], 1'b0};
    if (lanes_reg == LANES_4) begin
      drive_bits = out_sh_reg[7:4];
      drive_oe   = 4'hF;
      sh_left    = {out_sh_reg[3:0], 4'h0};
    end else if (lanes_reg == LANES_2) begin
      drive_bits = {2'b00, out_sh_reg[7:6]};
      drive_oe   = 4'h3;
      sh_left    = {out_sh_reg[5:0], 2'b00};
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_sh_reg <= 8'h00;
      ocnt_reg   <= 5'h00;
      io_out_reg <= 4'h0;
      io_oe_reg  <= 4'h0;
    end else if (enter_data) begin
      out_sh_reg <= first_src;
      ocnt_reg   <= byte_clks(lanes_next);
    end else if (tx_fall) begin
      io_out_reg <= drive_bits;
      io_oe_reg  <= drive_oe;
      out_sh_reg <= byte_end ? next_src : sh_left;
      ocnt_reg   <= byte_end ? byte_clks(lanes_reg) : ocnt_reg - ONE_CLK;
    end else if (cs_high || sclk_fall) begin
      io_oe_reg  <= 4'h0;
    end
  end

  // ****************************************************************
  // write enable latch and self-timed program cycle
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wel_reg <= 1'b0;
    end else if (busy_done) begin
      wel_reg <= 1'b0;
    end else if (opcode_done && !wip_reg && cmd_dec.kind == K_WREN) begin
      wel_reg <= 1'b1;
    end else if (opcode_done && !wip_reg && cmd_dec.kind == K_WRDI) begin
      wel_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wip_reg      <= 1'b0;
      busy_cnt_reg <= '0;
    end else if (prog_start) begin
      wip_reg      <= 1'b1;
      busy_cnt_reg <= '0;
    end else if (busy_done) begin
      wip_reg      <= 1'b0;
    end else if (wip_reg) begin
      busy_cnt_reg <= busy_cnt_reg + BUSY_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || addr_done) begin
      byte_seen_reg <= 1'b0;
    end else if (prog_byte) begin
      byte_seen_reg <= 1'b1;
    end
  end

  // page buffer: later bytes overwrite earlier ones at the same offset
  always_ff @(posedge clk_i) begin
    if (prog_byte) begin
      pbuf[page_off] <= rx_shift[7:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_valid
      always_ff @(posedge clk_i) begin
        if (reset_i || (addr_done && cmd_reg.kind == K_PROG)) begin
          pvalid_reg[gi] <= 1'b0;
        end else if (prog_byte && page_off == PAGE_BITS'(gi)) begin
          pvalid_reg[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // commit one buffered byte per clock; untouched bytes keep old data
  wire [PAGE_BITS-1:0] wr_off = busy_cnt_reg[PAGE_BITS-1:0];
  wire mem_we = wip_reg & (busy_cnt_reg < BUSY_CNT_W'(PAGE_BYTES)) &
                pvalid_reg[wr_off];

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[{addr_reg[MEM_ADDR_W-1:PAGE_BITS], wr_off}] <= pbuf[wr_off];
    end
  end

  assign io_line_o            = io_out_reg;
  assign io_line_oe_o         = io_oe_reg;
  assign write_in_progress_o  = wip_reg;
  assign write_enable_latch_o = wel_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_deselect_quiet;
    cs_high |=> io_line_oe_o == 4'h0;
  endproperty
  a_deselect_quiet: assert property (p_deselect_quiet)
    else $error("lines still driven after select rose");

  property p_change_on_fall;
    $changed(io_line_o) |-> $past(sclk_fall);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall)
    else $error("output bit changed away from a falling edge");

  property p_busy_ignore;
    opcode_done && wip_reg |=> state_reg == ST_IGNORE;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("command accepted while busy");

  property p_wren;
    opcode_done && !wip_reg && cmd_dec.kind == K_WREN |=> wel_reg;
  endproperty
  a_wren: assert property (p_wren)
    else $error("write enable did not set latch");

  property p_wel_end;
    $fell(wip_reg) |-> !wel_reg;
  endproperty
  a_wel_end: assert property (p_wel_end)
    else $error("latch not cleared at cycle end");

  property p_wip_start;
    prog_start |=> wip_reg [*8];
  endproperty
  a_wip_start: assert property (p_wip_start)
    else $error("program cycle did not start");

  property p_read_inc;
    byte_end && is_read |=>
      addr_reg == MEM_ADDR_W'($past(addr_reg) + 1'b1);
  endproperty
  a_read_inc: assert property (p_read_inc)
    else $error("read address did not advance");

  property p_read_wrap;
    byte_end && is_read && addr_reg == '1 |=> addr_reg == '0;
  endproperty
  a_read_wrap: assert property (p_read_wrap)
    else $error("read address did not wrap to zero");

  property p_page_stay;
    prog_byte |=> addr_reg[MEM_ADDR_W-1:PAGE_BITS] ==
                  $past(addr_reg[MEM_ADDR_W-1:PAGE_BITS]);
  endproperty
  a_page_stay: assert property (p_page_stay)
    else $error("program data left its page");

  property p_prog_wel;
    state_reg == ST_PROG |-> wel_reg;
  endproperty
  a_prog_wel: assert property (p_prog_wel)
    else $error("program accepted without write enable");

  c_quad_read: cover property (tx_fall && is_read && lanes_reg == LANES_4);
  c_program:   cover property (prog_start);
  c_silicon:   cover property (byte_end && cmd_reg.kind == K_SILID);
  c_devid:     cover property (byte_end && cmd_reg.kind == K_DEVID);

endmodule // sfce_engine

/* File: rtl/sfce_pkg.sv */
// constants, types and command layouts of the serial flash command engine
package sfce_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  // self-timed page program time
  localparam int PROG_TIME_NS  = 20000;
  // least time, so the cycle count rounds up
  localparam int PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_CNT_W    = 16;

  // ****************************************************************
  // opcodes
  // ****************************************************************
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_FAST  = 8'h0B;
  localparam logic [7:0] OP_DUAL  = 8'hBB;
  localparam logic [7:0] OP_QUAD  = 8'hEB;
  localparam logic [7:0] OP_DEVID = 8'h9F;
  localparam logic [7:0] OP_SILID = 8'hAB;
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_PROG  = 8'h02;
  localparam logic [7:0] OP_QPROG = 8'h32;

  // ****************************************************************
  // lanes, phase lengths in serial clocks, page layout
  // ****************************************************************
  localparam logic [2:0] LANES_1      = 3'h1;
  localparam logic [2:0] LANES_2      = 3'h2;
  localparam logic [2:0] LANES_4      = 3'h4;
  localparam logic [4:0] OPCODE_CLKS  = 5'h08;
  localparam logic [4:0] ADDR_CLKS_1  = 5'h18;
  localparam logic [4:0] ADDR_CLKS_2  = 5'h0C;
  localparam logic [4:0] ADDR_CLKS_4  = 5'h06;
  localparam logic [4:0] DUMMY_FAST   = 5'h08;
  localparam logic [4:0] DUMMY_DUAL   = 5'h04;
  localparam logic [4:0] DUMMY_QUAD   = 5'h06;
  localparam logic [4:0] DUMMY_NONE   = 5'h00;
  localparam logic [4:0] SILID_CLKS   = 5'h18;
  localparam logic [4:0] BYTE_CLKS_1  = 5'h08;
  localparam logic [4:0] BYTE_CLKS_2  = 5'h04;
  localparam logic [4:0] BYTE_CLKS_4  = 5'h02;
  localparam logic [4:0] ONE_CLK      = 5'h01;
  localparam int         ADDR_BITS    = 24;
  localparam int         PAGE_BITS    = 8;
  localparam int         PAGE_BYTES   = 256;

  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_PROG, ST_IGNORE
  } sfce_state_t;

  typedef enum logic [2:0] {
    K_NONE, K_READ, K_DEVID, K_SILID, K_PROG, K_WREN, K_WRDI
  } sfce_kind_t;

  typedef struct packed {
    sfce_kind_t  kind;
    logic [2:0]  addr_lanes;
    logic [2:0]  data_lanes;
    logic [4:0]  addr_clks;
    logic [4:0]  dummy_clks;
  } sfce_cmd_t;

endpackage

/* File: verification/sfce_host_model.sv */
// host-side model: drives select, serial clock and the data lines
`timescale 1ns/1ps

module sfce_host_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] io_line_i,
  output logic            select_active_low_o,
  output logic            serial_clock_o,
  output logic      [3:0] io_line_o,
  output logic      [3:0] io_line_oe_o
);
  initial begin
    select_active_low_o = 1'b1;
    serial_clock_o      = 1'b0;
    io_line_o           = 4'h0;
    io_line_oe_o        = 4'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // serial clock stands low outside frames; gap exceeds 3 clk
  task automatic frame(input bit on);
    tick(1);
    select_active_low_o = !on;
    io_line_oe_o        = 4'h0;
    tick(4);
  endtask

  // n serial clocks of l lanes, msb first; rd releases and samples
  // 160 ns period keeps well under the single read limit
  task automatic xfer(input logic [31:0] v, input int n, l,
                      input bit rd, output logic [31:0] r);
    logic [3:0] m;
    m = 4'((1 << l) - 1);
    r = 32'h0;
    for (int k = 0; k < n; k++) begin
      io_line_oe_o = rd ? 4'h0 : m;
      io_line_o    = 4'(v >> ((n - 1 - k) * l)) & m;
      tick(4);
      r = (r << l) | (l == 1 ? 32'(io_line_i[1]) : 32'(io_line_i & m));
      serial_clock_o = 1'b1;
      tick(4);
      serial_clock_o = 1'b0;
    end
  endtask
endmodule // sfce_host_model

/* File: verification/tb.sv */
// self-checking bench of the serial flash command engine
`timescale 1ns/1ps

module tb;
  import sfce_pkg::*;
  localparam logic [7:0] DEV_ID = 8'h6B; // arbitrary value
  localparam logic [7:0] SIL_ID = 8'hD4; // arbitrary value
  logic        clk_i;
  logic        reset_i;
  logic        sel;
  logic        sck;
  logic [3:0]  d_o;
  logic [3:0]  d_oe;
  logic [3:0]  h_o;
  logic [3:0]  h_oe;
  logic [3:0]  io_w;
  logic [3:0]  io_q;
  logic        wip;
  logic        wel;
  logic [31:0] r;
  int          num_errors;
  int          n_compared;
  time         t_wip;

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // a released line shows the inverse of its last level
  assign io_w = (d_oe & d_o) | (~d_oe & h_oe & h_o) | (~d_oe & ~h_oe & ~io_q);
  always @(posedge clk_i) io_q <= reset_i ? 4'h0 : io_w;

  // start of the self-timed cycle, to measure its full length
  always @(posedge wip) t_wip = $time;

  sfce_engine #(.DEVICE_ID(DEV_ID), .SILICON_ID(SIL_ID)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .select_active_low_i(sel),
    .serial_clock_i(sck), .io_line_i(io_w), .io_line_o(d_o),
    .io_line_oe_o(d_oe), .write_in_progress_o(wip),
    .write_enable_latch_o(wel));

  sfce_host_model host (
    .clk_i(clk_i), .io_line_i(io_w), .select_active_low_o(sel),
    .serial_clock_o(sck), .io_line_o(h_o), .io_line_oe_o(h_oe));

  task automatic stop_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // opcode, address on al lanes (none if 0), nb bytes on dl lanes
  task automatic wr(input logic [7:0] op, input int al,
                    input logic [23:0] a, input int dl, nb,
                    input logic [31:0] d);
    host.frame(1);
    host.xfer(32'(op), 8, 1, 0, r);
    if (al > 0) host.xfer(32'(a), 24 / al, al, 0, r);
    if (nb > 0) host.xfer(d, nb * 8 / dl, dl, 0, r);
  endtask

  task automatic rd(input logic [7:0] op, input int al,
                    input logic [23:0] a, input int dm, dl, nb,
                    input logic [31:0] e, input logic [3:0] eoe);
    wr(op, al, a, 1, 0, 32'h0);
    if (dm > 0) host.xfer(32'h0, dm, 1, 1, r);
    host.xfer(32'h0, nb * 8 / dl, dl, 1, r);
    chk(r, e, "read data");
    host.tick(4);
    chk(32'(d_oe), 32'(eoe), "drive lanes");
    host.frame(0);
    chk(32'(d_oe), 32'h0, "release");
  endtask

  task automatic prog_wait();
    int n;
    int el;
    n = 0;
    while (wip === 1'b1 && n < 2000) begin
      host.tick(1);
      n++;
    end
    if (n >= 2000) begin
      chk(32'(wip), 32'h0, "busy timeout");
      stop_test();
    end
    el = int'(($time - t_wip) / CLK_PERIOD_NS);
    chk(32'(el), 32'(PROG_CYCLES), "busy cycles");
    chk(32'(wel), 32'h0, "latch after cycle");
  endtask

  task automatic t_reset();
    chk({30'h0, wip, wel}, 32'h0, "reset flags");
    chk(32'(d_oe), 32'h0, "reset drive");
  endtask

  task automatic t_latch();
    wr(OP_WREN, 0, 24'h0, 1, 0, 32'h0);
    host.frame(0);
    chk(32'(wel), 32'h1, "set latch");
    wr(OP_WRDI, 0, 24'h0, 1, 0, 32'h0);
    host.frame(0);
    chk(32'(wel), 32'h0, "clear latch");
    wr(OP_PROG, 1, 24'h000010, 1, 1, 32'h99);
    host.frame(0);
    chk(32'(wip), 32'h0, "program refused");
    wr(OP_WREN, 0, 24'h0, 1, 0, 32'h0);
    host.frame(0);
    chk(32'(wel), 32'h1, "set latch again");
    reset_i = 1'b1;
    host.tick(2);
    reset_i = 1'b0;
    host.tick(3);
    chk({30'h0, wip, wel}, 32'h0, "mid-run reset");
    chk(32'(d_oe), 32'h0, "mid-run reset drive");
  endtask

  task automatic t_prog();
    wr(OP_WREN, 0, 24'h0, 1, 0, 32'h0);
    host.frame(0);
    // every target byte is programmed once only, as if freshly erased
    wr(OP_PROG, 1, 24'h0001FE, 1, 3, 32'h112233);
    host.frame(0);
    chk(32'(wip), 32'h1, "cycle started");
    wr(OP_READ, 1, 24'h0001FE, 1, 0, 32'h0);
    host.xfer(32'h0, 8, 1, 1, r);
    chk(32'(d_oe), 32'h0, "read while busy");
    chk(32'(wip), 32'h1, "cycle undisturbed");
    host.frame(0);
    prog_wait();
    wr(OP_WREN, 0, 24'h0, 1, 0, 32'h0);
    host.frame(0);
    wr(OP_PROG, 1, 24'h00FFFF, 1, 1, 32'h44);
    host.frame(0);
    prog_wait();
    wr(OP_WREN, 0, 24'h0, 1, 0, 32'h0);
    host.frame(0);
    wr(OP_QPROG, 1, 24'h000000, 4, 2, 32'h5566);
    host.frame(0);
    prog_wait();
  endtask

  task automatic t_reads();
    rd(OP_READ, 1, 24'h0001FE, 0, 1, 2, 32'h1122, 4'h2);
    rd(OP_READ, 1, 24'h00FFFF, 0, 1, 2, 32'h4455, 4'h2);
    rd(OP_FAST, 1, 24'h000100, 8, 1, 1, 32'h33, 4'h2);
    rd(OP_DUAL, 2, 24'h000000, 4, 2, 2, 32'h5566, 4'h3);
    rd(OP_QUAD, 4, 24'h000001, 6, 4, 1, 32'h66, 4'hF);
  endtask

  task automatic t_ids();
    rd(OP_DEVID, 0, 24'h0, 0, 1, 1, 32'(DEV_ID), 4'h0);
    rd(OP_SILID, 0, 24'h0, 24, 1, 2, {16'h0, SIL_ID, SIL_ID}, 4'h2);
  endtask

  initial begin
    reset_i    = 1'b1;
    num_errors = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_i);
    #1 reset_i = 1'b0;
    host.tick(3);
    t_reset();
    t_latch();
    t_prog();
    t_reads();
    t_ids();
    stop_test();
  end
endmodule // tb
